// ==== rtl/dfp_fan_pwm.sv ====
`timescale 1ns/10ps
// Function
// - bit0 of setting one forces pin one high
// - bit0 of setting two forces pin two high
// - duty code gives high steps out of 64
// - channel one rate from select, source, multiplier
// - channel two rate from select, source, multiplier
// - control bit 2 doubles channel one rate
// - control bit 3 doubles channel two rate
// - control bits 0,1 sources; 2,3 multipliers
module dfp_fan_pwm #(
    parameter logic [15:0] DIV_S0_C0 = 16'h0040,       // steps of clk per pwm step
    parameter logic [15:0] DIV_S0_C1 = 16'h0080,
    parameter logic [15:0] DIV_S1_C0 = 16'h0100,
    parameter logic [15:0] DIV_S1_C1 = 16'h0200
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [dfp_pkg::DFP_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [dfp_pkg::DFP_DAT_W-1:0] wb_dat_i,
    output logic      [dfp_pkg::DFP_DAT_W-1:0] wb_dat_o,
    output logic                               wb_ack_o,
    output logic                               fan_drive_out_one_o,
    output logic                               fan_drive_out_two_o
);
    import dfp_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]            set_q    [2];    // software setting registers
    logic [3:0]            ctrl_q;          // clock sources and multipliers
    logic [DFP_DUTY_W-1:0] shadow_q [2];    // duty code in force this period
    logic [DFP_DUTY_W-1:0] cnt_q    [2];    // free period counters
    logic [DFP_DIV_W-1:0]  pre_q    [2];    // step prescalers
    logic [DFP_DIV_W-1:0]  lim      [2];    // prescaler terminal value
    logic                  out_q    [2];    // pin flops
    logic                  ack_q;           // bus answer
    logic [DFP_DAT_W-1:0]  rdat_q;          // read data
    logic [7:0]            idx;             // word index of access
    logic                  wr_go;           // write commits this edge

    // ------------------------------------------------------------------
    // step rate decode
    // ------------------------------------------------------------------
    // base divider from source and select, multiplier halves it;
    // a divider of zero would wrap the limit, so it is clamped to one step
    function automatic logic [DFP_DIV_W-1:0] step_lim(input logic src,
                                                     input logic sel,
                                                     input logic mul);
        logic [DFP_DIV_W-1:0] d;
        case ({src, sel})
            2'b00:   d = DIV_S0_C0;
            2'b01:   d = DIV_S0_C1;
            2'b10:   d = DIV_S1_C0;
            default: d = DIV_S1_C1;
        endcase
        if (mul) begin
            d = d >> 1;     // doubled output frequency
        end
        if (d == 16'h0000) begin
            d = 16'h0001;
        end
        return d - 16'h0001;
    endfunction

    // per channel rate from its select bit and its control bits
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            lim[ch] = step_lim(ctrl_q[DFP_F_SRC + ch],
                               set_q[ch][DFP_F_CSEL],
                               ctrl_q[DFP_F_MUL + ch]);
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    assign idx   = wb_adr_i[DFP_ADR_W-1:2];
    // write lands on the edge where the master sees ack
    assign wr_go = ce_i & ack_q & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

    // one wait state answer, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // read mux, unmapped addresses answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (ce_i && wb_cyc_i && wb_stb_i && !ack_q) begin
            rdat_q <= '0;
            case (idx)
                DFP_IDX_SET_ONE: rdat_q[7:0] <= set_q[0];
                DFP_IDX_SET_TWO: rdat_q[7:0] <= set_q[1];
                DFP_IDX_CTRL:    rdat_q[3:0] <= ctrl_q;
                DFP_IDX_STAT: begin
                    rdat_q[DFP_F_ST_OUT]                         <= out_q[0];
                    rdat_q[DFP_F_ST_OUT+1]                       <= out_q[1];
                    rdat_q[DFP_F_ST_CNT1 +: DFP_DUTY_W]          <= cnt_q[0];
                    rdat_q[DFP_F_ST_CNT2 +: DFP_DUTY_W]          <= cnt_q[1];
                end
                default: rdat_q <= '0;  // unmapped reads zero
            endcase
        end
    end

    // setting registers, only byte lane 0 carries data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            set_q[0] <= DFP_SET_RST;
            set_q[1] <= DFP_SET_RST;
        end else if (wr_go) begin
            if (idx == DFP_IDX_SET_ONE) begin
                set_q[0] <= wb_dat_i[7:0];
            end
            if (idx == DFP_IDX_SET_TWO) begin
                set_q[1] <= wb_dat_i[7:0];
            end
        end
    end

    // control bits; divisor bits of the real register live elsewhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= DFP_CTRL_RST;
        end else if (wr_go && idx == DFP_IDX_CTRL) begin
            ctrl_q <= wb_dat_i[3:0];
        end
    end

    // ------------------------------------------------------------------
    // pwm channels
    // ------------------------------------------------------------------
    // prescaler and period counter; a rate change restarts the step
    // once the prescaler reaches or passes the new limit, even mid period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int ch = 0; ch < 2; ch++) begin
                pre_q[ch]    <= '0;
                cnt_q[ch]    <= '0;
                shadow_q[ch] <= '0;
            end
        end else if (ce_i) begin
            for (int ch = 0; ch < 2; ch++) begin
                if (pre_q[ch] >= lim[ch]) begin
                    pre_q[ch] <= '0;
                    cnt_q[ch] <= cnt_q[ch] + 6'h01;
                    // reload duty only at the wrap: no runt pulse
                    if (cnt_q[ch] == DFP_CNT_LAST) begin
                        shadow_q[ch] <= set_q[ch][DFP_F_DUTY_LO +: DFP_DUTY_W];
                    end
                end else begin
                    pre_q[ch] <= pre_q[ch] + 16'h0001;
                end
            end
        end
    end

    // pin flops; force overrides at once, duty compares step count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q[0] <= 1'b0;
            out_q[1] <= 1'b0;
        end else if (ce_i) begin
            for (int ch = 0; ch < 2; ch++) begin
                out_q[ch] <= set_q[ch][DFP_F_FORCE] |
                             (cnt_q[ch] < shadow_q[ch]);
            end
        end
    end

    assign wb_ack_o            = ack_q;
    assign wb_dat_o            = rdat_q;
    assign fan_drive_out_one_o = out_q[0];
    assign fan_drive_out_two_o = out_q[1];

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_force_one;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && set_q[0][DFP_F_FORCE]) |=> fan_drive_out_one_o;
    endproperty
    a_force_one: assert property (p_force_one) else $error("pin one not forced high");

    property p_force_two;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && set_q[1][DFP_F_FORCE]) |=> fan_drive_out_two_o;
    endproperty
    a_force_two: assert property (p_force_two) else $error("pin two not forced high");

    property p_duty_cmp;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !set_q[0][DFP_F_FORCE]) |=>
            (fan_drive_out_one_o == ($past(cnt_q[0]) < $past(shadow_q[0])));
    endproperty
    a_duty_cmp: assert property (p_duty_cmp) else $error("pin one duty wrong");

    property p_last_low;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !set_q[1][DFP_F_FORCE] && cnt_q[1] == DFP_CNT_LAST) |=> !fan_drive_out_two_o;
    endproperty
    a_last_low: assert property (p_last_low) else $error("last step not low");

    property p_step_one;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pre_q[0] == lim[0]) |=> (cnt_q[0] == $past(cnt_q[0]) + 6'h01 && pre_q[0] == 0);
    endproperty
    a_step_one: assert property (p_step_one) else $error("channel one step missed");

    property p_step_two;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pre_q[1] < lim[1]) |=> (cnt_q[1] == $past(cnt_q[1]));
    endproperty
    a_step_two: assert property (p_step_two) else $error("channel two stepped early");

    property p_mul_one;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl_q[DFP_F_MUL] && lim[0] > 0) |->
            ((lim[0] + 16'h0001) == (step_lim(ctrl_q[0], set_q[0][7], 1'b0) + 16'h0001) >> 1);
    endproperty
    a_mul_one: assert property (p_mul_one) else $error("channel one not doubled");

    property p_mul_two;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl_q[DFP_F_MUL+1]) |-> (lim[1] == step_lim(ctrl_q[1], set_q[1][7], 1'b0));
    endproperty
    a_mul_two: assert property (p_mul_two) else $error("channel two rate wrong");

    property p_ctrl_wr;
        @(posedge clk_i) disable iff (rst_i)
        (wr_go && idx == DFP_IDX_CTRL) |=> (ctrl_q == $past(wb_dat_i[3:0]));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

    property p_shadow_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(ce_i && pre_q[0] >= lim[0] && cnt_q[0] == DFP_CNT_LAST) |=> $stable(shadow_q[0]);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold)
        else $error("duty changed mid period");

    c_force:  cover property (@(posedge clk_i) set_q[0][DFP_F_FORCE] ##1 fan_drive_out_one_o);
    c_wrap:   cover property (@(posedge clk_i) ce_i && pre_q[1] >= lim[1] && cnt_q[1] == 6'h3f);
    c_double: cover property (@(posedge clk_i) ctrl_q[DFP_F_MUL] && cnt_q[0] == 6'h20);
endmodule

// ==== rtl/dfp_pkg.sv ====
// ----------------------------------------------------------------------
// dual fan pwm constants
// ----------------------------------------------------------------------
package dfp_pkg;
    // bus geometry
    localparam int         DFP_ADR_W        = 10;       // byte address width
    localparam int         DFP_DAT_W        = 32;       // wishbone data width
    // register indices, byte address is four times the index
    localparam logic [7:0] DFP_IDX_SET_ONE  = 8'h56;    // fan_pwm_setting_one
    localparam logic [7:0] DFP_IDX_SET_TWO  = 8'h57;    // fan_pwm_setting_two
    localparam logic [7:0] DFP_IDX_CTRL     = 8'h58;    // fan clock control bits
    localparam logic [7:0] DFP_IDX_STAT     = 8'h60;    // channel status, read only
    // reset values
    localparam logic [7:0] DFP_SET_RST      = 8'h00;    // both setting registers
    localparam logic [3:0] DFP_CTRL_RST     = 4'h0;     // clock source and multipliers
    // setting register fields
    localparam int         DFP_F_FORCE      = 0;        // force pin high
    localparam int         DFP_F_DUTY_LO    = 1;        // duty code low bit
    localparam int         DFP_F_CSEL       = 7;        // clock select
    // control register fields, per channel ch: source at ch, multiplier at ch+2
    localparam int         DFP_F_SRC        = 0;        // first clock source bit
    localparam int         DFP_F_MUL        = 2;        // first multiplier bit
    // status register fields
    localparam int         DFP_F_ST_OUT     = 0;        // pin levels at bits 1:0
    localparam int         DFP_F_ST_CNT1    = 8;        // first period counter
    localparam int         DFP_F_ST_CNT2    = 16;       // second period counter
    // pwm geometry
    localparam int         DFP_DUTY_W       = 6;        // steps per period is 64
    localparam logic [5:0] DFP_CNT_LAST     = 6'h3f;    // last step of a period
    localparam int         DFP_DIV_W        = 16;       // step divider width
endpackage

// ==== testbench/dfp_fan_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// fan drive load: measures high time and period of one pwm pin
// ----------------------------------------------------------------------
module dfp_fan_model (
    input  wire logic        clk_i,
    input  wire logic        pin_i,
    output logic             meas_o,
    output logic [15:0]      high_o,
    output logic [15:0]      per_o
);
    logic        last_q;   // pin level one clock ago
    logic [15:0] hcnt_q;   // high clocks since last rising edge
    logic [15:0] pcnt_q;   // clocks since last rising edge
    // report at each rising edge; the first report after a change is partial,
    // so the bench throws the first few away
    always_ff @(posedge clk_i) begin
        last_q <= pin_i;
        meas_o <= 1'b0;
        if (pin_i && !last_q) begin
            meas_o <= 1'b1;
            high_o <= hcnt_q;
            per_o  <= pcnt_q;
            pcnt_q <= 16'h0001;
            hcnt_q <= 16'h0001;
        end else begin
            pcnt_q <= pcnt_q + 16'h0001;
            hcnt_q <= hcnt_q + {15'h0000, pin_i};
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import dfp_pkg::*;
    // ----------------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------------
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 cyc   = 1'b0;
    logic                 stb   = 1'b0;
    logic                 we    = 1'b0;
    logic                 ce    = 1'b1;  // clock enable to the block
    logic                 pch   = 1'b0;  // which pin the load watches
    logic [DFP_ADR_W-1:0] adr   = '0;
    logic [3:0]           sel   = 4'hf;
    logic [DFP_DAT_W-1:0] wdat  = '0;
    logic [31:0]          rng   = 32'h9d1f7ed5;
    logic [31:0]          ew;
    logic [31:0]          v;
    logic [DFP_DAT_W-1:0] dat_o;
    logic                 ack, pin1, pin2, meas;
    logic [15:0]          high, per;
    logic [31:0]          rq[$];         // expected read data
    logic [31:0]          pq[$];         // expected {high, period}
    int                   failures = 0;
    int                   checks   = 0;
    // small divisors keep a pwm period at most 512 clocks
    localparam logic [15:0] DV [4] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008};
    always #5 clk_i = ~clk_i;
    dfp_fan_pwm #(.DIV_S0_C0(DV[0]), .DIV_S0_C1(DV[1]), .DIV_S1_C0(DV[2]),
        .DIV_S1_C1(DV[3])) dfp_fan_pwm_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fan_drive_out_one_o(pin1), .fan_drive_out_two_o(pin2));
    dfp_fan_model dfp_fan_model_i (.clk_i(clk_i), .pin_i(pch ? pin2 : pin1),
        .meas_o(meas), .high_o(high), .per_o(per));
    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic report_and_stop();
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one classic cycle; a spent wait bound ends the run as a failure
    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        sel <= s;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            report_and_stop();
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        rq.push_back(exp);
        wb(1'b0, idx, 32'h0, 4'hf);
    endtask
    task automatic wait_meas(input int k);
        int n;
        n = 0;
        repeat (k) begin
            @(posedge clk_i);
            while (meas !== 1'b1 && n < 4000) begin @(posedge clk_i); n++; end
        end
        if (n >= 4000) begin failures++; report_and_stop(); end
    endtask
    // program one channel, skip settling periods, then expect one full period
    task automatic pwm(input logic c, input logic [5:0] duty, input logic s7,
                       input logic src, input logic mul);
        logic [15:0] st;
        st = DV[{src, s7}] >> mul;
        wb(1'b1, c ? DFP_IDX_SET_TWO : DFP_IDX_SET_ONE, {24'h0, s7, duty, 1'b0}, 4'hf);
        wb(1'b1, DFP_IDX_CTRL, {28'h0, mul & c, mul & !c, src & c, src & !c}, 4'hf);
        rd(DFP_IDX_CTRL, {28'h0, mul & c, mul & !c, src & c, src & !c});
        pch <= c;
        wait_meas(3);
        // step off the reporting edge so the watcher cannot take this note early
        @(posedge clk_i);
        pq.push_back({duty * st, 16'h0040 * st});
        wait_meas(1);
    endtask
    // ----------------------------------------------------------------------
    // result watcher: oldest note against each result as it appears
    // ----------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
            ew = rq.pop_front();
            `CHK(dat_o, ew)
        end
        if (meas === 1'b1 && pq.size() > 0) begin
            ew = pq.pop_front();
            `CHK({high, per}, ew)
        end
    end
    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        int bad;
        logic hold;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(DFP_IDX_SET_ONE, 32'h0);
        rd(DFP_IDX_SET_TWO, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = {24'h0, xs() >> 24};
            wb(1'b1, i[0] ? DFP_IDX_SET_TWO : DFP_IDX_SET_ONE, v, 4'hf);
            wb(1'b1, i[0] ? DFP_IDX_SET_TWO : DFP_IDX_SET_ONE, ~v, 4'he);  // lane ignored
            rd(i[0] ? DFP_IDX_SET_TWO : DFP_IDX_SET_ONE, v);
        end
        wb(1'b1, 8'h40, 32'h000000ff, 4'hf);  // unmapped place
        rd(8'h40, 32'h0);
        // every clock-select, source and multiplier mix on both channels
        for (int k = 0; k < 16; k++) begin
            pwm(k[0], k == 0 ? 6'h3f : k == 1 ? 6'h20 : k == 2 ? 6'h01 : 6'(xs() % 63 + 1),
                k[3], k[2], k[1]);
        end
        // clock enable low freezes the period counters, so the pin must hold
        ce <= 1'b0;
        @(posedge clk_i);
        hold = pin2;
        bad  = 0;
        repeat (300) begin
            @(posedge clk_i);
            if (pin2 !== hold) bad++;
        end
        ce <= 1'b1;
        `CHK(bad, 0)
        // force high on one pin, all-zero duty on the other, then swap
        for (int c = 0; c < 2; c++) begin
            wb(1'b1, DFP_IDX_SET_ONE, c ? 32'h00 : 32'h0b, 4'hf);
            wb(1'b1, DFP_IDX_SET_TWO, c ? 32'h0b : 32'h00, 4'hf);
            repeat (600) @(posedge clk_i);
            bad = 0;
            repeat (600) begin @(posedge clk_i); if ({pin1, pin2} !== {!c[0], c[0]}) bad++; end
            `CHK(bad, 0)
        end
        // mid-run reset: pins drop, settings and control bits clear
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK({pin1, pin2}, 2'b00)
        rst_i <= 1'b0;
        rd(DFP_IDX_SET_ONE, 32'h0);
        rd(DFP_IDX_SET_TWO, 32'h0);
        rd(DFP_IDX_CTRL, 32'h0);
        // let the watcher take the last read before the verdict
        repeat (2) @(posedge clk_i);
        report_and_stop();
    end
endmodule
